// ---- core/debug_wire_ack_handshake.sv ----
`timescale 1ns/1ps
// Function
// - ack is 16 low cycles plus speedup
// - ack no sooner than 32 after end
// - bits take 16 cycles, host falling edge
// - timed reference: 128 low plus speedup
// - stop before execution withholds the ack
// - byte fetch decoded, bus read, then ack
// - fetched data returned as whole word
// - target starts ack with falling edge
// - stop during arrival discards the command
// - long low aborts, timed reference follows
// - firmware access completes, ack cancelled
// - resume commands survive abort, ack dropped
// - short low of four cancels silently
// - next falling edge starts new command
// - handshake on/off by command, off reset
// - handshake-on command acknowledges itself
// - reads/writes ack after bus cycle completes
// - halt and resume ack on mode change
// - resume-until-halt acks on background entry
// - single step acks on return
module debug_wire_ack_handshake (
	input  wire logic                                clk_sys,
	input  wire logic                                sys_rst,
	input  wire logic                                debug_wire_pin_i,   // sensed pin level
	output logic                                     debug_wire_pin_o,   // driven level
	output logic                                     debug_wire_pin_oe,  // high while driving
	input  wire logic                                cmd_valid,          // command end pulse
	input  wire debug_wire_pkg::cmd_kind_t           cmd_kind,           // kind at cmd_valid
	input  wire logic                                cmd_rx_active,      // command arriving
	input  wire logic                                bus_done,           // access complete
	input  wire logic [debug_wire_pkg::DATA_W-1:0]   bus_rdata,          // word from memory
	input  wire logic                                bg_enter,           // entered background
	input  wire logic                                bg_exit,            // left background
	input  wire logic                                stop_entry,         // cpu enters stop
	input  wire logic                                sys_stop_entry,     // system stop reached
	output logic                                     bit_end,            // 16th tick of a bit
	output logic                                     new_cmd_start,      // first bit after abort
	output logic                                     soft_reset,         // discard partial command
	output logic                                     cmd_cancel,         // drop pending command
	output logic                                     cmd_dropped,        // command lost to stop
	output logic                                     bus_req,            // start byte fetch
	output logic [debug_wire_pkg::DATA_W-1:0]        rd_data,            // fetched word
	output logic                                     hs_enabled,         // handshake state
	output logic                                     ack_pending         // ack outstanding
);

	// ----------------------------------------------------------------
	// pin synchroniser and own-drive mask
	// ----------------------------------------------------------------
	logic       pin_meta_q;                        // first stage, read by second only
	logic       pin_sync_q;                        // second stage
	logic       pin_prev_q;                        // previous synced level
	logic [2:0] oe_hist_q;                         // recent drive, covers sync lag

	// two stages since the host runs on its own clock
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pin_meta_q <= 1'b1;
			pin_sync_q <= 1'b1;
			pin_prev_q <= 1'b1;
			oe_hist_q  <= 3'h0;
		end else begin
			pin_meta_q <= debug_wire_pin_i;
			pin_sync_q <= pin_meta_q;
			pin_prev_q <= pin_sync_q;
			oe_hist_q  <= {oe_hist_q[1:0], debug_wire_pin_oe};
		end
	end

	// ----------------------------------------------------------------
	// main state
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		st_idle,                                   // pin released
		st_ack_low,                                // ack low drive
		st_ack_up,                                 // ack speedup
		st_sync_delay,                             // let host speedup end
		st_sync_low,                               // timed-reference low drive
		st_sync_up                                 // timed-reference speedup
	} state_t;

	state_t                                state_q, state_d;
	logic [debug_wire_pkg::CNT_W-1:0]      cnt_q, cnt_d;        // state timer
	logic [debug_wire_pkg::CNT_W-1:0]      lo_cnt_q, lo_cnt_d;  // host low length
	logic [debug_wire_pkg::CNT_W-1:0]      bit_cnt_q, bit_cnt_d; // bit timer
	logic [debug_wire_pkg::CNT_W-1:0]      since_q, since_d;    // cycles since command end
	debug_wire_pkg::cmd_kind_t             kind_q, kind_d;      // pending command kind
	logic                                  pend_q, pend_d;      // ack outstanding
	logic                                  done_q, done_d;      // completion seen
	logic                                  hs_q, hs_d;          // handshake enabled
	logic                                  drop_q, drop_d;      // swallow next command
	logic                                  aft_q, aft_d;        // abort seen, await edge
	logic                                  rdw_q, rdw_d;        // fetch outstanding
	logic [debug_wire_pkg::DATA_W-1:0]     rd_q, rd_d;
	logic                                  pin_o_d, pin_oe_d;
	logic                                  bit_end_d, new_cmd_d, soft_rst_d;
	logic                                  cancel_d, dropped_d, bus_req_d;
	logic                                  own;                 // own drive visible on pin
	logic                                  host_fall, host_rise;
	logic                                  sync_det, short_abort, abort_now;
	logic                                  accept, event_hit;

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		own         = debug_wire_pin_oe | (|oe_hist_q);
		host_fall   = pin_prev_q & ~pin_sync_q & ~own;
		host_rise   = ~pin_prev_q & pin_sync_q & ~own;
		// long low then release counts as timed-reference request
		sync_det    = host_rise && (lo_cnt_q >= debug_wire_pkg::SYNC_LOW_CYC);
		// a shorter low of four cycles only cancels while an ack is awaited
		short_abort = pend_q && !own && !pin_sync_q
		              && (lo_cnt_q == debug_wire_pkg::SHORT_ABORT_CYC - 8'h01);
		abort_now   = sync_det | short_abort;
		// commands lost to stop never become pending
		accept      = cmd_valid && !drop_q && !stop_entry && cmd_kind != debug_wire_pkg::cmd_hs_off
		              && (hs_q || cmd_kind == debug_wire_pkg::cmd_hs_on);

		// completion event that matches the pending kind
		unique case (kind_q)
			debug_wire_pkg::cmd_hw_read,
			debug_wire_pkg::cmd_hw_write,
			debug_wire_pkg::cmd_fw_read,
			debug_wire_pkg::cmd_fw_write:          event_hit = bus_done;
			debug_wire_pkg::cmd_halt:              event_hit = bg_enter;
			debug_wire_pkg::cmd_resume:            event_hit = bg_exit;
			debug_wire_pkg::cmd_resume_until_halt: event_hit = bg_enter;
			debug_wire_pkg::single_step_cmd:       event_hit = bg_enter;
			default:                               event_hit = 1'b1;      // hs_on acks at once
		endcase

		state_d    = state_q;
		cnt_d      = cnt_q;
		kind_d     = kind_q;
		pend_d     = pend_q;
		done_d     = done_q | (pend_q & event_hit);
		hs_d       = hs_q;
		drop_d     = drop_q;
		aft_d      = aft_q;
		rdw_d      = rdw_q;
		rd_d       = rd_q;
		pin_o_d    = 1'b0;
		pin_oe_d   = 1'b0;
		new_cmd_d  = 1'b0;
		soft_rst_d = sync_det;                     // partial command discarded
		cancel_d   = 1'b0;
		dropped_d  = 1'b0;
		bus_req_d  = 1'b0;

		// host low length, saturating; cleared whenever the pin is high
		if (!pin_sync_q && !own) begin
			lo_cnt_d = (lo_cnt_q == debug_wire_pkg::CNT_MAX) ? lo_cnt_q : lo_cnt_q + 8'h01;
		end else begin
			lo_cnt_d = 8'h00;
		end

		// every bit runs sixteen cycles from the host edge
		bit_end_d = (bit_cnt_q == debug_wire_pkg::BIT_CYC - 8'h01);
		if (host_fall) begin
			bit_cnt_d = 8'h01;
		end else if (bit_cnt_q != 8'h00 && !bit_end_d) begin
			bit_cnt_d = bit_cnt_q + 8'h01;
		end else begin
			bit_cnt_d = 8'h00;
		end

		// gap since command end, saturating at the minimum
		since_d = (since_q >= debug_wire_pkg::ACK_MIN_GAP) ? since_q : since_q + 8'h01;

		// handshake on/off; system stop also turns it off
		if (cmd_valid && !drop_q && cmd_kind == debug_wire_pkg::cmd_hs_on) begin
			hs_d = 1'b1;
		end else if (cmd_valid && !drop_q && cmd_kind == debug_wire_pkg::cmd_hs_off) begin
			hs_d = 1'b0;
		end else if (sys_stop_entry) begin
			hs_d = 1'b0;
		end

		// byte fetch runs with or without the handshake
		if (cmd_valid && !drop_q && !stop_entry && cmd_kind == debug_wire_pkg::cmd_hw_read) begin
			bus_req_d = 1'b1;
			rdw_d     = 1'b1;
		end else if (rdw_q && bus_done) begin
			rd_d  = bus_rdata;                     // whole word, host picks the byte
			rdw_d = 1'b0;
		end

		// stop while a command arrives: swallow it
		if (stop_entry && cmd_rx_active) begin
			drop_d = 1'b1;
		end else if (cmd_valid && drop_q) begin
			drop_d    = 1'b0;
			dropped_d = 1'b1;
		end

		// pending flag; a new accept restarts the gap
		if (accept) begin
			pend_d  = 1'b1;
			done_d  = 1'b0;
			kind_d  = cmd_kind;
			since_d = 8'h01;                       // command end is this tick
		end else if (stop_entry && pend_q) begin
			pend_d    = 1'b0;                      // not executed, not pending
			done_d    = 1'b0;
			dropped_d = 1'b1;
		end else if (abort_now && pend_q) begin
			pend_d = 1'b0;
			done_d = 1'b0;
			// only hardware accesses are withdrawn; firmware and run commands go on
			cancel_d = (kind_q == debug_wire_pkg::cmd_hw_read)
			           || (kind_q == debug_wire_pkg::cmd_hw_write);
		end

		// next host edge after an abort starts a fresh command
		if (abort_now) begin
			aft_d = 1'b1;
		end else if (aft_q && host_fall) begin
			aft_d     = 1'b0;
			new_cmd_d = 1'b1;
		end

		// pin driver sequencing
		unique case (state_q)
			st_idle: begin
				if (sync_det) begin
					state_d = st_sync_delay;
					cnt_d   = 8'h00;
				// a fresh accept in this cycle wins; the old ack is not started
				end else if (pend_q && done_q && !accept && !abort_now && !stop_entry && pin_sync_q
				             && !own && since_q >= debug_wire_pkg::ACK_MIN_GAP) begin
					state_d  = st_ack_low;
					cnt_d    = 8'h00;
					pend_d   = 1'b0;
					done_d   = 1'b0;
					pin_oe_d = 1'b1;               // target makes the falling edge
				end
			end
			st_ack_low: begin
				pin_oe_d = 1'b1;
				if (cnt_q == debug_wire_pkg::ACK_LOW_CYC - 8'h01) begin
					state_d = st_ack_up;
					pin_o_d = 1'b1;
				end else begin
					cnt_d = cnt_q + 8'h01;
				end
			end
			st_ack_up: begin
				state_d = st_idle;                 // one-cycle speedup ends the ack
			end
			st_sync_delay: begin
				if (cnt_q == debug_wire_pkg::SYNC_DELAY_CYC - 8'h01) begin
					state_d  = st_sync_low;
					cnt_d    = 8'h00;
					pin_oe_d = 1'b1;
				end else begin
					cnt_d = cnt_q + 8'h01;
				end
			end
			st_sync_low: begin
				pin_oe_d = 1'b1;
				if (cnt_q == debug_wire_pkg::SYNC_LOW_CYC - 8'h01) begin
					state_d = st_sync_up;
					pin_o_d = 1'b1;
				end else begin
					cnt_d = cnt_q + 8'h01;
				end
			end
			st_sync_up: begin
				state_d = st_idle;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// state registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state_q           <= st_idle;
			cnt_q             <= 8'h00;
			lo_cnt_q          <= 8'h00;
			bit_cnt_q         <= 8'h00;
			since_q           <= 8'h00;
			kind_q            <= debug_wire_pkg::cmd_hs_on;
			pend_q            <= 1'b0;
			done_q            <= 1'b0;
			hs_q              <= debug_wire_pkg::HS_EN_RST;
			drop_q            <= 1'b0;
			aft_q             <= 1'b0;
			rdw_q             <= 1'b0;
			rd_q              <= 16'h0000;
			debug_wire_pin_o  <= 1'b0;
			debug_wire_pin_oe <= 1'b0;
			bit_end           <= 1'b0;
			new_cmd_start     <= 1'b0;
			soft_reset        <= 1'b0;
			cmd_cancel        <= 1'b0;
			cmd_dropped       <= 1'b0;
			bus_req           <= 1'b0;
		end else begin
			state_q           <= state_d;
			cnt_q             <= cnt_d;
			lo_cnt_q          <= lo_cnt_d;
			bit_cnt_q         <= bit_cnt_d;
			since_q           <= since_d;
			kind_q            <= kind_d;
			pend_q            <= pend_d;
			done_q            <= done_d;
			hs_q              <= hs_d;
			drop_q            <= drop_d;
			aft_q             <= aft_d;
			rdw_q             <= rdw_d;
			rd_q              <= rd_d;
			debug_wire_pin_o  <= pin_o_d;
			debug_wire_pin_oe <= pin_oe_d;
			bit_end           <= bit_end_d;
			new_cmd_start     <= new_cmd_d;
			soft_reset        <= soft_rst_d;
			cmd_cancel        <= cancel_d;
			cmd_dropped       <= dropped_d;
			bus_req           <= bus_req_d;
		end
	end

	// status straight from flip-flops
	assign rd_data     = rd_q;
	assign hs_enabled  = hs_q;
	assign ack_pending = pend_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_ack_low_len: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$rose(state_q == st_ack_low) |-> (debug_wire_pin_oe && !debug_wire_pin_o)[*8]
		##1 (debug_wire_pin_oe && !debug_wire_pin_o)[*8]
		##1 (debug_wire_pin_oe && debug_wire_pin_o) ##1 !debug_wire_pin_oe)
		else $error("ack low drive length wrong");

	a_ack_min_gap: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$rose(state_q == st_ack_low) |-> $past(since_q) >= debug_wire_pkg::ACK_MIN_GAP)
		else $error("ack started too soon after command end");

	a_bit_tick: assert property (@(posedge clk_sys) disable iff (sys_rst)
		bit_end |-> $past(host_fall, 16))
		else $error("bit end not sixteen cycles after host edge");

	a_sync_low_len: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$fell(state_q == st_sync_low) |-> state_q == st_sync_up
		&& $past(cnt_q) == debug_wire_pkg::SYNC_LOW_CYC - 8'h01 ##1 state_q == st_idle)
		else $error("timed reference pulse length wrong");

	a_stop_no_ack: assert property (@(posedge clk_sys) disable iff (sys_rst)
		stop_entry && state_q == st_idle |=> !ack_pending && state_q != st_ack_low)
		else $error("ack survived stop entry");

	a_ack_edge_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$rose(debug_wire_pin_oe) && state_q == st_ack_low |-> !debug_wire_pin_o)
		else $error("ack did not start with a low drive");

	a_abort_clears: assert property (@(posedge clk_sys) disable iff (sys_rst)
		abort_now && !accept |=> !ack_pending ##1 state_q != st_ack_low)
		else $error("abort left an ack pending");

	a_sync_follows: assert property (@(posedge clk_sys) disable iff (sys_rst)
		sync_det && state_q == st_idle |-> ##17 $rose(state_q == st_sync_low))
		else $error("timed reference did not follow long low");

	a_new_cmd_edge: assert property (@(posedge clk_sys) disable iff (sys_rst)
		aft_q && !abort_now && host_fall |=> new_cmd_start)
		else $error("first edge after abort not flagged");

	a_hs_off_cmd: assert property (@(posedge clk_sys) disable iff (sys_rst)
		cmd_valid && !drop_q && cmd_kind == debug_wire_pkg::cmd_hs_off |=> !hs_enabled)
		else $error("handshake still on after off command");

endmodule

// ---- include/debug_wire_pkg.sv ----
package debug_wire_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int CNT_W  = 8;                 // width of every cycle counter
	localparam int DATA_W = 16;                // fetched data travels as a word

	// ----------------------------------------------------------------
	// timing counts, in serial clock cycles
	// ----------------------------------------------------------------
	localparam logic [CNT_W-1:0] BIT_CYC         = 8'h10; // cycles per serial bit
	localparam logic [CNT_W-1:0] ACK_LOW_CYC     = 8'h10; // acknowledge low time
	localparam logic [CNT_W-1:0] ACK_MIN_GAP     = 8'h20; // least gap, command end to ack
	localparam logic [CNT_W-1:0] SYNC_LOW_CYC    = 8'h80; // timed-reference low time
	localparam logic [CNT_W-1:0] SYNC_DELAY_CYC  = 8'h10; // wait for host speedup to end
	localparam logic [CNT_W-1:0] SHORT_ABORT_CYC = 8'h04; // least low time of a short abort
	localparam logic [CNT_W-1:0] CNT_MAX         = 8'hFF; // saturation of the low counter

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic HS_EN_RST = 1'b0;         // handshake off after reset

	// ----------------------------------------------------------------
	// command kinds handed over by the serial decoder
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		cmd_hw_read,                            // hardware byte fetch
		cmd_hw_write,                           // hardware byte store
		cmd_fw_read,                            // firmware read
		cmd_fw_write,                           // firmware write
		cmd_halt,                               // enter background mode
		cmd_resume,                             // leave background mode
		cmd_resume_until_halt,                  // run until background re-entry
		single_step_cmd,                        // one application instruction
		cmd_hs_on,                              // handshake on
		cmd_hs_off                              // handshake off
	} cmd_kind_t;

endpackage

// ---- sim/debug_adapter_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// external debug adapter: drives low pulses on the shared pin
// ----------------------------------------------------------------
module debug_adapter_model (
	input  wire logic       clk_sys,  // target clock, adapter is only loosely tied to it
	input  wire logic       pin_lvl,  // resolved pin level
	input  wire logic       go,       // start one low pulse
	input  wire logic [8:0] low_len,  // low time in cycles
	output logic            host_oe,  // high while the adapter drives
	output logic            host_o,   // driven level
	output logic            busy      // pulse in progress
);
	logic [8:0] cnt_q;                // low cycles left

	initial begin
		host_oe = 1'b0;
		host_o = 1'b0;
		busy = 1'b0;
		cnt_q = 9'h000;
	end

	// starts only on a high pin, so a target drive is never fought
	always @(posedge clk_sys) begin
		if (go && !busy && pin_lvl) begin
			busy <= 1'b1;
			cnt_q <= low_len;
			host_oe <= 1'b1;
			host_o <= 1'b0;
		end else if (busy && cnt_q > 9'h001) begin // long or short low
			cnt_q <= cnt_q - 9'h001;
		end else if (busy && !host_o) begin // one speedup cycle
			host_o <= 1'b1;
		end else if (busy) begin // let the pull-up hold the line
			host_oe <= 1'b0;
			host_o <= 1'b0;
			busy <= 1'b0;
		end
	end
endmodule

// ---- sim/debug_wire_ack_handshake_test.sv ----
`timescale 1ns/1ps
module debug_wire_ack_handshake_test;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic clk_sys, sys_rst, pin_lvl, pin_o, pin_oe, host_oe, host_o, go, busy;
	logic cmd_valid, cmd_rx_active, bus_done, bg_enter, bg_exit, stop_entry, sys_stop_entry;
	logic bit_end, new_cmd_start, soft_reset, cmd_cancel, cmd_dropped, bus_req;
	logic hs_enabled, ack_pending;
	debug_wire_pkg::cmd_kind_t cmd_kind;
	logic [15:0] bus_rdata, rd_data;
	logic [8:0]  low_len;
	logic [6:0]  seen;                // sticky pulses: oe,bitend,new,soft,cancel,drop,busreq
	int          err_total, checks, cyc;

	debug_wire_ack_handshake dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.debug_wire_pin_i(pin_lvl), .debug_wire_pin_o(pin_o), .debug_wire_pin_oe(pin_oe),
		.cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_rx_active(cmd_rx_active),
		.bus_done(bus_done), .bus_rdata(bus_rdata), .bg_enter(bg_enter), .bg_exit(bg_exit),
		.stop_entry(stop_entry), .sys_stop_entry(sys_stop_entry), .bit_end(bit_end),
		.new_cmd_start(new_cmd_start), .soft_reset(soft_reset), .cmd_cancel(cmd_cancel),
		.cmd_dropped(cmd_dropped), .bus_req(bus_req), .rd_data(rd_data),
		.hs_enabled(hs_enabled), .ack_pending(ack_pending));
	debug_adapter_model host_u (.clk_sys(clk_sys), .pin_lvl(pin_lvl), .go(go),
		.low_len(low_len), .host_oe(host_oe), .host_o(host_o), .busy(busy));

	// open-drain wire with pull-up
	assign pin_lvl = ((pin_oe && !pin_o) || (host_oe && !host_o)) ? 1'b0 : 1'b1;

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// pulses are caught here so no sampling moment can miss them
	always @(posedge clk_sys) begin
		seen <= seen | {pin_oe, bit_end, new_cmd_start, soft_reset, cmd_cancel, cmd_dropped, bus_req};
		cyc <= cyc + 1;
		if (cyc == 6000) begin // hang guard
			err_total++;
			end_of_test();
		end
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			err_total++;
			$display("wrong value %s expected %0h seen %0h", nm, e, s);
		end
	endtask
	task tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task cmd(input debug_wire_pkg::cmd_kind_t k);
		cmd_kind = k;
		cmd_valid = 1'b1;
		tick(1);
		cmd_valid = 1'b0;
	endtask
	// 0 bus_done, 1 bg_enter, 2 bg_exit, 3 stop_entry, 4 sys_stop_entry
	task pulse(input int w);
		{sys_stop_entry, stop_entry, bg_exit, bg_enter, bus_done} = 5'h01 << w;
		tick(1);
		{sys_stop_entry, stop_entry, bg_exit, bg_enter, bus_done} = 5'h00;
	endtask
	task host(input logic [8:0] n);
		low_len = n;
		go = 1'b1;
		tick(1);
		go = 1'b0;
	endtask
	// waits for a target drive, measures its low part, checks the speedup
	task drive(output int w, output int lo);
		w = 0;
		lo = 0;
		while (!pin_oe && w < 400) begin
			tick(1);
			w++;
		end
		while (pin_oe && !pin_o && lo < 300) begin
			tick(1);
			lo++;
		end
		chk("speedup", {pin_oe, pin_o}, 2'b11);
		tick(1);
		chk("release", pin_oe, 1'b0);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_hs_on;
		int w, lo;
		chk("hs after reset", hs_enabled, 1'b0);
		chk("pending after reset", ack_pending, 1'b0);
		cmd(debug_wire_pkg::cmd_hs_on);
		chk("pending", ack_pending, 1'b1);
		chk("hs on", hs_enabled, 1'b1);
		drive(w, lo);
		chk("ack gap ok", w >= 32, 1'b1);
		chk("ack low", lo, 16);
		chk("pending cleared", ack_pending, 1'b0);
		$display("hs_on test done");
	endtask
	task t_read;
		int w, lo;
		seen = 7'h00;
		cmd(debug_wire_pkg::cmd_hw_read);
		tick(1);
		chk("bus_req", seen[0], 1'b1);
		tick(10);
		bus_rdata = 16'hA55A;
		pulse(0);
		tick(1);
		chk("rd_data", rd_data, 16'hA55A);
		drive(w, lo);
		chk("read ack low", lo, 16);
		$display("read test done");
	endtask
	// every completion kind; a wrong event first must not finish it
	task t_kinds;
		debug_wire_pkg::cmd_kind_t k[6];
		int ev[6];
		int w, lo;
		k = '{debug_wire_pkg::cmd_hw_write, debug_wire_pkg::cmd_fw_write, debug_wire_pkg::cmd_halt,
			debug_wire_pkg::cmd_resume, debug_wire_pkg::cmd_resume_until_halt,
			debug_wire_pkg::single_step_cmd};
		ev = '{0, 0, 1, 2, 1, 1};
		for (int i = 0; i < 6; i++) begin
			cmd(k[i]);
			tick(40);
			seen = 7'h00;
			pulse((ev[i] + 1) % 3);
			tick(5);
			chk("no early ack", seen[6], 1'b0);
			pulse(ev[i]);
			drive(w, lo);
			chk("kind ack low", lo, 16);
		end
		$display("kinds test done");
	endtask
	// short low while pending: ack gone, no response, no cancel
	// nc: an earlier abort makes the pulse's falling edge a new command start
	task t_short(input debug_wire_pkg::cmd_kind_t k, input int e, input logic nc);
		cmd(k);
		tick(3);
		seen = 7'h00;
		host(9'h005); // abort the unacknowledged command first
		tick(12);
		chk("short pending", ack_pending, 1'b0);
		pulse(e);
		tick(50);
		chk("short silent", {seen[6], seen[3:2]}, 3'h0);
		chk("short bit_end", seen[5], 1'b1);
		chk("short new_cmd", seen[4], nc);
		$display("short abort test done");
	endtask
	task t_long;
		int w, lo;
		cmd(debug_wire_pkg::cmd_hw_read);
		tick(3);
		seen = 7'h00;
		host(9'h082);
		drive(w, lo);
		chk("sync low", lo, 128);
		chk("soft_reset", seen[3], 1'b1);
		chk("cancel", seen[2], 1'b1);
		chk("long pending", ack_pending, 1'b0);
		tick(5);
		seen = 7'h00;
		host(9'h004);
		tick(25);
		chk("new_cmd_start", seen[4], 1'b1);
		chk("bit_end", seen[5], 1'b1);
		$display("long abort test done");
	endtask
	task t_stop;
		seen = 7'h00;
		cmd(debug_wire_pkg::cmd_halt);
		tick(2);
		pulse(3);
		tick(1);
		chk("stop pending", ack_pending, 1'b0);
		chk("stop dropped", seen[1], 1'b1);
		pulse(1);
		tick(40);
		seen = 7'h00;
		cmd_rx_active = 1'b1;
		pulse(3);
		tick(5);
		cmd(debug_wire_pkg::cmd_hw_write);
		cmd_rx_active = 1'b0;
		tick(2);
		chk("swallow pending", ack_pending, 1'b0);
		chk("swallow dropped", seen[1], 1'b1);
		pulse(0);
		tick(40);
		chk("no ack after stop", seen[6], 1'b0);
		pulse(4);
		tick(1);
		chk("sys stop hs", hs_enabled, 1'b0);
		$display("stop test done");
	endtask
	task t_off;
		int w, lo;
		cmd(debug_wire_pkg::cmd_hs_on);
		drive(w, lo);
		cmd(debug_wire_pkg::cmd_hs_off);
		tick(1);
		chk("hs off", {hs_enabled, ack_pending}, 2'b00);
		cmd(debug_wire_pkg::cmd_hw_write);
		tick(1); // no ack awaited, host times its own delay
		chk("off no pending", ack_pending, 1'b0);
		$display("hs_off test done");
	endtask

	task end_of_test;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		{cmd_valid, cmd_rx_active, bus_done, bg_enter, bg_exit, stop_entry, sys_stop_entry} = 7'h00;
		cmd_kind = debug_wire_pkg::cmd_hw_read;
		bus_rdata = 16'h0000;
		low_len = 9'h000;
		go = 1'b0;
		seen = 7'h00;
		{err_total, checks, cyc} = 0;
		sys_rst = 1'b1;
		tick(2);
		sys_rst = 1'b0;
		tick(1);
		t_hs_on();
		t_read();
		t_kinds();
		t_short(debug_wire_pkg::cmd_fw_read, 0, 1'b0);
		t_short(debug_wire_pkg::cmd_resume, 2, 1'b1);
		t_long();
		t_stop();
		t_off();
		end_of_test();
	end
endmodule
